// ==== rtl/pcm_pkg.sv ====
// Shared constants, register map and field layouts for the PLL clock manager.
// Assumes a 200 MHz system clock and a 32-bit APB register port.
package pcm_pkg;

  // System clock and timing figures
  localparam int CLK_SYS_MHZ = 200;
  localparam int LOCK_TIME_NS = 10000;
  localparam int LOCK_CYC = LOCK_TIME_NS * CLK_SYS_MHZ / 1000;
  localparam int REF_MIN_MHZ = 10;
  localparam int LOSS_CYC = 2 * CLK_SYS_MHZ / REF_MIN_MHZ;
  localparam int LOCK_PERIODS = 4;

  // Register byte offsets
  localparam logic [7:0] PAIR_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] IRQS_OFS = 8'h08;
  localparam logic [7:0] IRQM_OFS = 8'h0C;
  localparam logic [3:0] INST_BASE_SLOT = 4'h1;
  localparam logic [1:0] CFG_SUB = 2'h0;
  localparam logic [1:0] RATIO_SUB = 2'h1;
  localparam logic [1:0] PER_SUB = 2'h2;

  // Interrupt status bit positions
  localparam int IRQ_LOCK_POS = 0;
  localparam int IRQ_LOST_POS = 4;
  localparam int IRQ_TMO_POS = 8;
  localparam int IRQ_PAIR_POS = 12;
  localparam int IRQ_W = 13;

  // Programmable ranges
  localparam logic [7:0] MK_MIN = 8'h02;
  localparam logic [7:0] MK_MAX = 8'hA0;
  localparam logic [4:0] NV_MIN = 5'h01;
  localparam logic [4:0] NV_MAX = 5'h10;

  // Boost factor codes for the paired clocks
  typedef enum logic [1:0] {
    FAC_X1 = 2'b00,
    FAC_X2 = 2'b01,
    FAC_X4 = 2'b10
  } pcm_fac_t;

  // Per-instance control word, bits 23:0
  typedef struct packed {
    logic [7:0] fine;
    logic [5:0] rsvd;
    logic [1:0] quarter;
    logic gpio_oe;
    logic gpio_out;
    logic lvds;
    logic lock_pin_en;
    logic out_en;
    logic ext_fb;
    logic src_second;
    logic en;
  } pcm_cfg_t;

  // Per-instance ratio word, bits 31:0
  typedef struct packed {
    logic post_v;
    logic [1:0] rsvd1;
    logic [4:0] v;
    logic [2:0] rsvd0;
    logic [4:0] n;
    logic [7:0] k;
    logic [7:0] m;
  } pcm_ratio_t;

  // Paired-clock word, bits 4:0
  typedef struct packed {
    logic en;
    logic [1:0] f2;
    logic [1:0] f1;
  } pcm_pair_t;

  localparam logic [23:0] CFG_RST = 24'h00_0000;
  localparam logic [31:0] RATIO_RST = 32'h0101_0202;
  localparam logic [4:0] PAIR_RST = 5'h00;
  localparam logic [15:0] IRQM_RST = 16'h0000;

  // Loop state of one instance
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACQ = 2'b01,
    ST_LOCK = 2'b10
  } pcm_state_t;

endpackage

// ==== rtl/pcm_pll_core.sv ====
// One loop instance: reference tracking, lock detect and ratio clock synthesis.
// Assumes reference and feedback inputs already synchronous to clk_sys_i.
`timescale 1ns/10ps
module pcm_pll_core
  import pcm_pkg::*;
(
  input wire logic clk_sys_i, // System clock
  input wire logic resetn_i, // Async reset, active low
  input wire logic track_i, // Tracking allowed
  input wire logic ref_i, // Selected reference
  input wire logic fb_ext_i, // External feedback pin
  input wire pcm_cfg_t cfg_i, // Control word
  input wire pcm_ratio_t ratio_i, // Ratio word
  output logic clk_o, // Synthesised clock
  output logic locked_o, // Lock level
  output logic [15:0] period_o, // Measured reference period
  output logic ev_lock_o, // Lock gained pulse
  output logic ev_lost_o, // Lock lost pulse
  output logic ev_tmo_o // Lock timeout pulse
);

  pcm_state_t state, next_state;
  logic ref_q, fb_q, fb_seen;
  logic [15:0] cnt;
  logic [2:0] stab;
  logic [11:0] tmr;
  logic [28:0] acc;

  // Edge and period measurement
  wire ref_rise = ref_i & ~ref_q;
  wire fb_src = cfg_i.ext_fb ? fb_ext_i : clk_o;
  wire fb_rise = fb_src & ~fb_q;
  wire [15:0] per_new = (cnt == 16'hFFFF) ? cnt : cnt + 16'h0001;
  wire per_ok = ({1'b0, per_new} <= {1'b0, period_o} + 17'h0_0001)
    && ({1'b0, per_new} + 17'h0_0001 >= {1'b0, period_o});
  wire ref_gone = cnt >= 16'(LOSS_CYC);
  wire stable = stab == 3'(LOCK_PERIODS);

  // Ratio m/(n*post); differential mode multiplies straight to bit rate
  wire [4:0] n_eff = cfg_i.lvds ? 5'h01 : ratio_i.n;
  wire [7:0] post = cfg_i.lvds ? 8'h01 : (ratio_i.post_v ? {3'h0, ratio_i.v} : ratio_i.k);
  wire [28:0] lim = 29'(period_o) * 29'(n_eff) * 29'(post);
  wire [29:0] sum = {1'b0, acc} + {21'h00_0000, ratio_i.m, 1'b0};
  wire tick = (lim != 29'h0) && (sum >= {1'b0, lim});

  // Phase in 1/256 period: quarter steps plus signed fine delay
  wire [7:0] phase = {cfg_i.quarter, 6'h00} + cfg_i.fine;
  wire [7:0] adv = 8'(8'h00 - phase);
  wire [35:0] prod = 36'(adv[6:0]) * 36'(lim);
  wire [28:0] pre = prod[35:7];

  // Loop state decisions
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE: if (track_i) next_state = ST_ACQ;
      ST_ACQ:
      begin
        if (!track_i) next_state = ST_IDLE;
        else if (stable && fb_seen && !ref_gone) next_state = ST_LOCK;
      end
      ST_LOCK:
      begin
        if (!track_i) next_state = ST_IDLE;
        else if (ref_gone || (ref_rise && !per_ok)) next_state = ST_ACQ;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  assign ev_lock_o = (state == ST_ACQ) && (next_state == ST_LOCK);
  assign ev_lost_o = (state == ST_LOCK) && (next_state == ST_ACQ);
  assign ev_tmo_o = (state == ST_ACQ) && (tmr == 12'(LOCK_CYC - 1));
  assign locked_o = state == ST_LOCK;

  // State, edges and reference period
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state <= ST_IDLE;
      ref_q <= 1'b0;
      fb_q <= 1'b0;
      cnt <= 16'h0000;
      period_o <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      ref_q <= ref_i;
      fb_q <= fb_src;
      cnt <= ref_rise ? 16'h0000 : per_new;
      if (ref_rise) period_o <= per_new;
    end
  end

  // Stability count, feedback seen and acquisition timer
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      stab <= 3'h0;
      fb_seen <= 1'b0;
      tmr <= 12'h000;
    end
    else
    begin
      if (state == ST_IDLE || ref_gone) stab <= 3'h0;
      else if (ref_rise) stab <= !per_ok ? 3'h0 : (stable ? stab : stab + 3'h1);
      fb_seen <= (state == ST_IDLE) ? 1'b0 : (fb_seen | fb_rise);
      if (state != ST_ACQ) tmr <= 12'h000;
      else if (tmr != 12'(LOCK_CYC)) tmr <= tmr + 12'h001;
    end
  end

  // Ratio synthesis; realigned to reference edges while acquiring
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      acc <= 29'h0000_0000;
      clk_o <= 1'b0;
    end
    else if (state == ST_IDLE)
    begin
      acc <= 29'h0000_0000;
      clk_o <= 1'b0;
    end
    else if (state == ST_ACQ && ref_rise)
    begin
      acc <= pre;
      clk_o <= ~adv[7]; // High in the first half of the period
    end
    else if (tick)
    begin
      acc <= 29'(sum - {1'b0, lim});
      clk_o <= ~clk_o;
    end
    else
    begin
      acc <= sum[28:0];
    end
  end

endmodule

// ==== rtl/pcm_clock_mgr.sv ====
// Top of the PLL clock manager: APB registers, interrupts, pin muxing, instances.
// Assumes APB from a master on clk_sys_i and pins already synchronous to it.
`timescale 1ns/10ps

// Behaviour
// - paired factors legal only if first not above second
// - second input feeds both paired loops together
// - output equals input times m over n*post
// - n and v range one to sixteen
// - phase moves in quarter period steps
// - delay adjustable up to one full period
// - lock output high once loop locked
// - lock pin optional, otherwise general purpose I/O
// - up to four independent loops, own settings
// - only two loops may serve differential mode
// - synthesised clock drivable onto an output pin
// - feedback selectable through external pin
// - differential mode multiplies to serial bit rate
// - loop aligns output to reference edges
// - tracking starts only after configuration completes
// - lock within ten microseconds of valid reference
module pcm_clock_mgr
  import pcm_pkg::*;
#(
  parameter int NUM_PLL = 4, // Loop instances
  parameter int LVDS_PLLS = 2 // Instances able to serve differential mode
)
(
  input wire logic clk_sys_i, // System clock
  input wire logic resetn_i, // Async reset, active low
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB direction
  input wire logic [7:0] paddr_i, // APB byte address
  input wire logic [31:0] pwdata_i, // APB write data
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error
  input wire logic cfg_done_i, // Device configuration complete
  input wire logic first_dedicated_clock_input_i, // First reference pin
  input wire logic second_dedicated_clock_input_i, // Second reference pin
  input wire logic [NUM_PLL-1:0] fb_clk_i, // External feedback pins
  output logic [NUM_PLL-1:0] clk_out_o, // Clock output pins
  output logic [NUM_PLL-1:0] clk_out_oe_o, // Clock output enables
  output logic [LVDS_PLLS-1:0] lvds_clk_o, // Serial capture clocks
  input wire logic [NUM_PLL-1:0] lock_pin_i, // Lock or GPIO pin input
  output logic [NUM_PLL-1:0] lock_pin_o, // Lock or GPIO pin output
  output logic [NUM_PLL-1:0] lock_pin_oe_o, // Lock or GPIO pin enable
  output logic [NUM_PLL-1:0] locked_o, // Lock levels
  output logic irq_o // Interrupt, active high
);

  // Parameter sanity
  if (NUM_PLL < 2 || NUM_PLL > 4 || LVDS_PLLS < 1 || LVDS_PLLS > NUM_PLL)
  begin : g_chk
    $error("pcm_clock_mgr: unsupported instance counts");
  end

  pcm_cfg_t cfg [NUM_PLL];
  pcm_ratio_t ratio [NUM_PLL];
  pcm_pair_t pair;
  logic [IRQ_W-1:0] irq_stat, irq_mask;
  logic [NUM_PLL-1:0] ev_lock, ev_lost, ev_tmo, core_clk;
  logic [15:0] period [NUM_PLL];

  // Bus phases and address decode
  wire acc_ph = psel_i & penable_i;
  wire setup_rd = psel_i & ~penable_i & ~pwrite_i;
  wire wr = acc_ph & pwrite_i;
  wire [3:0] slot = paddr_i[7:4];
  wire [1:0] sub = paddr_i[3:2];
  wire [3:0] slot_off = slot - INST_BASE_SLOT;
  wire [1:0] idx = slot_off[1:0];
  wire inst_hit = (slot >= INST_BASE_SLOT) && ({1'b0, slot_off} < 5'(NUM_PLL))
    && (sub != 2'h3) && (paddr_i[1:0] == 2'h0);
  wire hit_pair = paddr_i == PAIR_OFS;
  wire hit_stat = paddr_i == STAT_OFS;
  wire hit_irqs = paddr_i == IRQS_OFS;
  wire hit_irqm = paddr_i == IRQM_OFS;
  wire mapped = hit_pair | hit_stat | hit_irqs | hit_irqm | inst_hit;

  // Write value checks
  pcm_ratio_t wr_ratio;
  pcm_pair_t wr_pair;
  assign wr_ratio = pcm_ratio_t'(pwdata_i);
  assign wr_pair = pcm_pair_t'(pwdata_i[4:0]);
  wire mk_ok = (wr_ratio.m >= MK_MIN) && (wr_ratio.m <= MK_MAX)
    && (wr_ratio.k >= MK_MIN) && (wr_ratio.k <= MK_MAX);
  wire nv_ok = (wr_ratio.n >= NV_MIN) && (wr_ratio.n <= NV_MAX)
    && (wr_ratio.v >= NV_MIN) && (wr_ratio.v <= NV_MAX);
  wire ratio_ok = mk_ok && nv_ok;
  wire pair_ok = (wr_pair.f1 != 2'b11) && (wr_pair.f2 != 2'b11)
    && (wr_pair.f1 <= wr_pair.f2);
  wire bad_ratio = inst_hit && (sub == RATIO_SUB) && !ratio_ok;
  wire bad_pair = hit_pair && !pair_ok;
  wire wr_err = pwrite_i && (bad_ratio || bad_pair || (inst_hit && sub == PER_SUB)
    || hit_stat);

  // Zero-wait slave; errors flagged in the access phase
  assign pready_o = 1'b1;
  assign pslverr_o = acc_ph && (!mapped || wr_err);

  wire wr_pair_ok = wr && hit_pair && pair_ok;
  wire wr_irqs = wr && hit_irqs;
  wire wr_irqm = wr && hit_irqm;
  wire wr_cfg = wr && inst_hit && (sub == CFG_SUB);
  wire wr_ratio_ok = wr && inst_hit && (sub == RATIO_SUB) && ratio_ok;

  // Differential mode only accepted on the capable instances
  pcm_cfg_t wr_cfg_val;
  always_comb
  begin
    wr_cfg_val = pcm_cfg_t'(pwdata_i[23:0]);
    wr_cfg_val.rsvd = 6'h00;
    if ({30'h0, idx} >= LVDS_PLLS) wr_cfg_val.lvds = 1'b0;
  end

  // Global registers
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pair <= pcm_pair_t'(PAIR_RST);
      irq_mask <= IRQM_RST[IRQ_W-1:0];
    end
    else
    begin
      if (wr_pair_ok) pair <= wr_pair;
      if (wr_irqm) irq_mask <= pwdata_i[IRQ_W-1:0];
    end
  end

  // Per-instance registers
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      for (int i = 0; i < NUM_PLL; i++)
      begin
        cfg[i] <= pcm_cfg_t'(CFG_RST);
        ratio[i] <= pcm_ratio_t'(RATIO_RST);
      end
    end
    else
    begin
      for (int i = 0; i < NUM_PLL; i++)
      begin
        if (wr_cfg && idx == 2'(i)) cfg[i] <= wr_cfg_val;
        if (wr_ratio_ok && idx == 2'(i)) ratio[i] <= wr_ratio;
      end
    end
  end

  // Event collection; a new event wins over a clear
  logic [IRQ_W-1:0] ev_vec;
  always_comb
  begin
    ev_vec = '0;
    ev_vec[IRQ_PAIR_POS] = wr && bad_pair;
    for (int i = 0; i < NUM_PLL; i++)
    begin
      ev_vec[IRQ_LOCK_POS + i] = ev_lock[i];
      ev_vec[IRQ_LOST_POS + i] = ev_lost[i];
      ev_vec[IRQ_TMO_POS + i] = ev_tmo[i];
    end
  end

  wire [IRQ_W-1:0] clr_vec = wr_irqs ? pwdata_i[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] next_irq_stat = (irq_stat & ~clr_vec) | ev_vec;

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      irq_stat <= '0;
    else
      irq_stat <= next_irq_stat;
  end

  assign irq_o = |(irq_stat & irq_mask);

  // Read data mux
  logic [31:0] inst_rd;
  always_comb
  begin
    inst_rd = 32'h0000_0000;
    for (int i = 0; i < NUM_PLL; i++)
    begin
      if (idx == 2'(i))
      begin
        case (sub)
          CFG_SUB: inst_rd = {8'h00, cfg[i]};
          RATIO_SUB: inst_rd = ratio[i];
          PER_SUB: inst_rd = {16'h0000, period[i]};
          default: inst_rd = 32'h0000_0000;
        endcase
      end
    end
  end

  wire [7:0] stat_rd = {4'(lock_pin_i), 4'(locked_o)};
  wire [31:0] next_prdata = hit_pair ? {27'h000_0000, pair}
    : hit_stat ? {24'h00_0000, stat_rd}
    : hit_irqs ? {{(32-IRQ_W){1'b0}}, irq_stat}
    : hit_irqm ? {{(32-IRQ_W){1'b0}}, irq_mask}
    : inst_hit ? inst_rd : 32'h0000_0000;

  // Read data captured in the setup phase
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      prdata_o <= 32'h0000_0000;
    else if (setup_rd)
      prdata_o <= next_prdata;
  end

  // Paired ratio: m = 2 * factor over k = 2, n = 1
  function automatic logic [7:0] pcm_fac_m(input logic [1:0] code);
    case (code)
      FAC_X1: pcm_fac_m = 8'h02;
      FAC_X2: pcm_fac_m = 8'h04;
      FAC_X4: pcm_fac_m = 8'h08;
      default: pcm_fac_m = 8'h02;
    endcase
  endfunction

  // Loop instances with source selection and pin muxing
  for (genvar g = 0; g < NUM_PLL; g++)
  begin : g_pll
    wire paired = pair.en && (g < 2);
    wire [7:0] pair_m = pcm_fac_m((g == 0) ? pair.f1 : pair.f2);
    wire ref_sel = (paired || cfg[g].src_second)
      ? second_dedicated_clock_input_i : first_dedicated_clock_input_i;
    wire track = cfg[g].en && cfg_done_i;
    pcm_ratio_t eff_ratio;
    pcm_cfg_t eff_cfg;
    always_comb
    begin
      eff_ratio = ratio[g];
      eff_cfg = cfg[g];
      if (paired)
      begin
        eff_ratio.m = pair_m;
        eff_ratio.k = MK_MIN;
        eff_ratio.n = NV_MIN;
        eff_ratio.post_v = 1'b0;
        eff_cfg.lvds = 1'b0;
      end
    end

    pcm_pll_core u_core (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .track_i(track),
      .ref_i(ref_sel),
      .fb_ext_i(fb_clk_i[g]),
      .cfg_i(eff_cfg),
      .ratio_i(eff_ratio),
      .clk_o(core_clk[g]),
      .locked_o(locked_o[g]),
      .period_o(period[g]),
      .ev_lock_o(ev_lock[g]),
      .ev_lost_o(ev_lost[g]),
      .ev_tmo_o(ev_tmo[g])
    );

    wire to_pin = cfg[g].out_en && !eff_cfg.lvds;
    assign clk_out_o[g] = to_pin & core_clk[g];
    assign clk_out_oe_o[g] = to_pin;
    assign lock_pin_o[g] = cfg[g].lock_pin_en ? locked_o[g] : cfg[g].gpio_out;
    assign lock_pin_oe_o[g] = cfg[g].lock_pin_en | cfg[g].gpio_oe;
    if (g < LVDS_PLLS)
    begin : g_lvds
      assign lvds_clk_o[g] = eff_cfg.lvds & core_clk[g];
    end
  end

endmodule

// ==== bench/pcm_clock_mgr_sva.sv ====
// Concurrent checks on the clock manager's pins.
// Assumes binding onto pcm_clock_mgr; sees only its ports.
`timescale 1ns/10ps
module pcm_clock_mgr_sva
  import pcm_pkg::*;
#(
  parameter int NUM_PLL = 4 // Loop instances
)
(
  input wire logic clk_sys_i, // System clock
  input wire logic resetn_i, // Async reset, active low
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB direction
  input wire logic [7:0] paddr_i, // APB byte address
  input wire logic [31:0] pwdata_i, // APB write data
  input wire logic pslverr_o, // APB error
  input wire logic cfg_done_i, // Configuration complete
  input wire logic first_dedicated_clock_input_i, // First reference
  input wire logic second_dedicated_clock_input_i, // Second reference
  input wire logic [NUM_PLL-1:0] locked_o, // Lock levels
  input wire logic irq_o // Interrupt
);
  localparam int SILENT = LOSS_CYC + 8;
  logic [1:0] ref_q;
  logic [7:0] quiet;
  logic [7:0] next_quiet;
  logic ref_rise;
  logic wr_acc;
  logic wr_pair;
  logic wr_ratio;
  logic pair_bad;
  logic [4:0] n_f;
  logic [4:0] v_f;

  // Write decode and field extraction
  assign wr_acc = psel_i && penable_i && pwrite_i;
  assign wr_pair = wr_acc && (paddr_i == PAIR_OFS);
  assign wr_ratio = wr_acc && paddr_i[3:0] == 4'h4 && paddr_i[7:4] >= 4'h1
    && int'(paddr_i[7:4]) <= NUM_PLL;
  assign pair_bad = pwdata_i[1:0] == 2'h3 || pwdata_i[3:2] == 2'h3
    || pwdata_i[1:0] > pwdata_i[3:2];
  assign n_f = pwdata_i[20:16];
  assign v_f = pwdata_i[28:24];

  // Cycles since the last rising edge on either reference
  assign ref_rise = (first_dedicated_clock_input_i && !ref_q[0])
    || (second_dedicated_clock_input_i && !ref_q[1]);
  assign next_quiet = ref_rise ? 8'h00 : (quiet == 8'hFF ? quiet : quiet + 8'h01);

  // Reference history and silence counter
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ref_q <= 2'h0;
      quiet <= 8'h00;
    end
    else
    begin
      ref_q <= {second_dedicated_clock_input_i, first_dedicated_clock_input_i};
      quiet <= next_quiet;
    end
  end

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  a_lock_cfg_gate: assert property (!cfg_done_i |-> ##2 locked_o == '0)
    else $error("lock held without configuration done");
  a_lock_ref_loss: assert property (quiet > SILENT |-> locked_o == '0)
    else $error("lock held with silent references");
  a_lock_not_early: assert property ($rose(resetn_i) |-> (locked_o == '0) [*8])
    else $error("lock right after reset");
  a_ratio_m_range: assert property (wr_ratio && (pwdata_i[7:0] < MK_MIN
    || pwdata_i[7:0] > MK_MAX) |-> pslverr_o)
    else $error("m outside range accepted");
  a_ratio_k_range: assert property (wr_ratio && (pwdata_i[15:8] < MK_MIN
    || pwdata_i[15:8] > MK_MAX) |-> pslverr_o)
    else $error("k outside range accepted");
  a_ratio_n_range: assert property (wr_ratio && (n_f < NV_MIN || n_f > NV_MAX)
    |-> pslverr_o)
    else $error("n outside range accepted");
  a_ratio_v_range: assert property (wr_ratio && (v_f < NV_MIN || v_f > NV_MAX)
    |-> pslverr_o)
    else $error("v outside range accepted");
  a_pair_refused: assert property (wr_pair && pair_bad |-> pslverr_o)
    else $error("illegal factor pairing accepted");
  a_pair_legal: assert property (wr_pair && !pair_bad |-> !pslverr_o)
    else $error("legal factor pairing refused");

  // Main scenarios reached
  c_lock_rise: cover property ($rose(locked_o[0]));
  c_irq_rise: cover property ($rose(irq_o));
  c_refused: cover property (wr_ratio && pslverr_o);
endmodule

bind pcm_clock_mgr pcm_clock_mgr_sva #(.NUM_PLL(NUM_PLL)) u_sva (
  .clk_sys_i(clk_sys_i),
  .resetn_i(resetn_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .paddr_i(paddr_i),
  .pwdata_i(pwdata_i),
  .pslverr_o(pslverr_o),
  .cfg_done_i(cfg_done_i),
  .first_dedicated_clock_input_i(first_dedicated_clock_input_i),
  .second_dedicated_clock_input_i(second_dedicated_clock_input_i),
  .locked_o(locked_o),
  .irq_o(irq_o)
);

// ==== bench/pcm_ref_model.sv ====
// Reference clock source and board feedback traces for the clock manager.
// Assumes the system clock paces it; edges fall on that grid.
`timescale 1ns/10ps
module pcm_ref_model
#(
  parameter int HALF = 10, // Half period in system cycles
  parameter int W = 4 // Feedback traces
)
(
  input wire logic clk_i, // System clock
  input wire logic run_i, // Source running
  input wire logic [W-1:0] clk_out_i, // Device clock pins
  output logic ref_o, // Reference clock
  output logic [W-1:0] fb_o // Device feedback pins
);
  int cnt = 0;

  initial ref_o = 1'b0;

  // Toggles while running, parked low when stopped
  always @(posedge clk_i)
  begin
    if (!run_i)
    begin
      cnt <= 0;
      ref_o <= 1'b0;
    end
    else if (cnt == HALF - 1)
    begin
      cnt <= 0;
      ref_o <= !ref_o;
    end
    else
      cnt <= cnt + 1;
  end

  // Board trace straight back to the feedback pin
  assign fb_o = clk_out_i;
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for the PLL clock manager over APB.
// Assumes the design package and the reference source model.
`timescale 1ns/10ps
module testbench;
  import pcm_pkg::*;
  typedef struct packed {
    logic wr;
    logic [31:0] exp;
    logic [31:0] msk;
    logic err;
  } pcm_note_t;
  // Eight refused ratio words, then four accepted ones
  localparam logic [31:0] RW [12] = '{32'h0101_0201, 32'h0101_02A1, 32'h0101_0102,
    32'h0101_A102, 32'h0100_0202, 32'h0111_0202, 32'h0001_0202, 32'h1101_0202,
    32'h0101_02A0, 32'h0101_A002, 32'h0110_0202, 32'h1001_0202};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic cfg_done = 1'b0;
  logic run = 1'b1;
  logic run1 = 1'b1;
  logic [31:0] prdata;
  logic pready, pslverr, ref1, ref2, irq;
  logic [3:0] fb, clk_out, clk_oe, lk_in, lk_o, lk_oe, locked;
  logic [1:0] lvds;
  int errors = 0;
  int n_compared = 0;
  pcm_note_t notes[$];

  always #2.5 clk = ~clk;

  // Pulled-up lock pins, driven when enabled
  assign lk_in = (lk_oe & lk_o) | ~lk_oe;

  pcm_ref_model #(.HALF(10), .W(4)) u_pcm_ref_model (.clk_i(clk), .run_i(run & run1),
    .clk_out_i(clk_out), .ref_o(ref1), .fb_o(fb));
  pcm_ref_model #(.HALF(5), .W(4)) u_pcm_ref_model_2 (.clk_i(clk), .run_i(run),
    .clk_out_i(clk_out), .ref_o(ref2), .fb_o());
  pcm_clock_mgr u_pcm_clock_mgr (.clk_sys_i(clk), .resetn_i(rstn), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .cfg_done_i(cfg_done),
    .first_dedicated_clock_input_i(ref1), .second_dedicated_clock_input_i(ref2),
    .fb_clk_i(fb), .clk_out_o(clk_out), .clk_out_oe_o(clk_oe), .lvds_clk_o(lvds),
    .lock_pin_i(lk_in), .lock_pin_o(lk_o), .lock_pin_oe_o(lk_oe), .locked_o(locked),
    .irq_o(irq));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // One APB transfer; the expected answer goes on the queue
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] e, input logic [31:0] m, input logic er);
    notes.push_back('{w, e, m, er});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_lock(input int i);
    int n;
    n = 0;
    while (locked[i] !== 1'b1 && n < LOCK_CYC)
    begin
      @(posedge clk);
      n++;
    end
    chk(32'(locked[i]), 32'h0000_0001, "lock level");
  endtask

  // Toggles of one clock pin over 200 cycles; bit s of {lvds, clk_out}
  task automatic tog(input int s, input int e);
    int c;
    logic [5:0] p;
    logic [5:0] q;
    c = 0;
    q = {lvds, clk_out};
    repeat (200)
    begin
      @(posedge clk);
      p = {lvds, clk_out};
      if (p[s] !== q[s])
        c++;
      q = p;
    end
    chk(32'(c >= e - 1 && c <= e + 1), 32'h0000_0001, "output toggles");
  endtask

  task automatic end_sim;
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Completed transfers against the oldest note
  always @(posedge clk)
  begin
    pcm_note_t nt;
    if (psel && penable && pready === 1'b1)
    begin
      nt = notes.pop_front();
      chk(32'(pslverr), 32'(nt.err), "bus error flag");
      if (!nt.wr)
        chk(prdata & nt.msk, nt.exp & nt.msk, "read data");
    end
  end

  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    end_sim;
  end

  // Main sequence
  initial
  begin
    logic [31:0] r [4];
    void'($urandom(32'hCC41_82B1));
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    apb(0, 8'h14, 0, RATIO_RST, '1, 0);
    apb(0, 8'h10, 0, CFG_RST, '1, 0);
    apb(0, 8'hF0, 0, 0, 0, 1);
    for (int j = 0; j < 12; j++)
      apb(1, 8'h44, RW[j], 0, 0, j < 8);
    apb(0, 8'h44, 0, 32'h1001_0202, '1, 0);
    // Random legal ratios kept apart per instance
    for (int j = 2; j < 4; j++)
    begin
      r[j] = {3'h0, 5'($urandom_range(1, 16)), 3'h0, 5'($urandom_range(1, 16)),
        8'($urandom_range(2, 160)), 8'($urandom_range(2, 160))};
      apb(1, 8'(8'h14 + 16 * j), r[j], 0, 0, 0);
    end
    for (int j = 2; j < 4; j++)
      apb(0, 8'(8'h14 + 16 * j), 0, r[j], '1, 0);
    // Every factor pairing, then the interrupt it raises
    for (int f1 = 0; f1 < 4; f1++)
      for (int f2 = 0; f2 < 4; f2++)
        apb(1, PAIR_OFS, {28'h0, 2'(f2), 2'(f1)}, 0, 0, f1 > f2 || f2 == 3);
    apb(0, PAIR_OFS, 0, 32'h0000_000A, 32'h0000_001F, 0);
    apb(1, IRQM_OFS, 32'h0000_1000, 0, 0, 0);
    chk(32'(irq), 32'h0000_0001, "irq raised");
    apb(1, IRQS_OFS, 32'h0000_1000, 0, 0, 0);
    chk(32'(irq), 32'h0000_0000, "irq cleared");
    // Three loops, held off until configuration is done
    apb(1, IRQM_OFS, 32'h0000_0001, 0, 0, 0);
    apb(1, 8'h10, 32'h0000_0019, 0, 0, 0);
    apb(1, 8'h20, 32'h0000_0023, 0, 0, 0);
    apb(0, 8'h20, 0, 32'h0000_0023, '1, 0);
    apb(1, 8'h40, 32'h0000_0020, 0, 0, 0);
    apb(0, 8'h40, 0, 32'h0000_0000, '1, 0);
    apb(1, 8'h30, 32'h0000_0005, 0, 0, 0);
    repeat (300) @(posedge clk);
    chk(32'(locked), 32'h0000_0000, "lock before done");
    cfg_done <= 1'b1;
    wait_lock(0);
    wait_lock(1);
    chk(32'(locked[2]), 32'h0000_0000, "no feedback edge");
    chk(32'({lk_oe[0], lk_o[0], clk_oe[0], irq}), 32'h0000_000F, "pins");
    apb(0, STAT_OFS, 0, 32'h0000_00F3, 32'h0000_00FF, 0);
    // Output toggles at the unit ratio; serial clock at twice the second input
    tog(0, 20);
    tog(5, 80);
    // Paired clocks served by the second input alone
    apb(1, PAIR_OFS, 32'h0000_0014, 0, 0, 0);
    run1 <= 1'b0;
    repeat (30) @(posedge clk);
    wait_lock(0);
    tog(0, 40);
    // Loss of both references
    run <= 1'b0;
    repeat (LOSS_CYC + 20) @(posedge clk);
    chk(32'({locked[1:0], lk_o[0]}), 32'h0000_0000, "lock after loss");
    apb(0, IRQS_OFS, 0, 32'h0000_0030, 32'h0000_0030, 0);
    end_sim;
  end
endmodule
